// File: design/tws_regs.vh
// Constants for the two-word burst SRAM device model.
// Assumes inclusion by every design file of the block.
`ifndef TWS_REGS_VH
`define TWS_REGS_VH
`define TWS_LANE_W 9
`define TWS_DATA_W 18
`define TWS_LANES 2
`define TWS_ADDR_W 8
`define TWS_SYNC_RST 2'b00
`define TWS_ST_IDLE 3'h0
`define TWS_ST_WR1 3'h1
`define TWS_ST_WR2 3'h2
`define TWS_ST_RD1 3'h3
`define TWS_ST_RD2 3'h4
`define TWS_ST_RD3 3'h5
`endif

// File: design/tws_sync.v
// Two-flop synchroniser with rising edge detect on the synchronised level.
// Assumes d is asynchronous to clock.
`timescale 1ns/1ps
`include "tws_regs.vh"
module tws_sync (
    input wire clock,
    input wire reset,
    input wire d,
    output wire level,
    output wire rise
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge clock) begin
        if (reset) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign level = s2_q;
    assign rise = s2_q & ~s3_q;
endmodule // tws_sync

// File: design/tws_buf2.v
// Two-entry valid/ready buffer for read words.
// Assumes source and sink share the clock.
`timescale 1ns/1ps
`include "tws_regs.vh"
module tws_buf2 #(
    parameter W = 18
) (
    input wire clock,
    input wire reset,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] m0_q;
    reg [W-1:0] m1_q;
    reg [1:0] cnt_q;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = m0_q;
    always @(posedge clock) begin
        if (reset) begin
            cnt_q <= 2'h0;
            m0_q <= {W{1'b0}};
            m1_q <= {W{1'b0}};
        end else begin
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
            if (pop) begin
                m0_q <= (cnt_q == 2'h2) ? m1_q : in_data;
                if (push && cnt_q == 2'h2)
                    m1_q <= in_data;
            end else if (push) begin
                if (cnt_q == 2'h0)
                    m0_q <= in_data;
                else
                    m1_q <= in_data;
            end
        end
    end
endmodule // tws_buf2

// File: design/tws_sram.v
// Two-word burst DDR SRAM device: command decode, burst, byte lanes, array.
// Assumes all link clocks and pins are slow against clock and are sampled.
`timescale 1ns/1ps
`include "tws_regs.vh"
module tws_sram #(
    parameter LANES = `TWS_LANES,
    parameter AW = `TWS_ADDR_W
) (
    input wire clock,
    input wire reset,
    input wire input_strobe_pos,
    input wire input_strobe_neg,
    input wire output_strobe_pos,
    input wire output_strobe_neg,
    input wire single_clock_mode,
    input wire load_n,
    input wire read_not_write,
    input wire [AW-1:0] address,
    input wire [LANES-1:0] lane_write_enable_n,
    input wire [LANES*`TWS_LANE_W-1:0] data_in,
    output reg [LANES*`TWS_LANE_W-1:0] data_out,
    output reg data_oe,
    output wire [LANES*`TWS_LANE_W-1:0] tap_data,
    output wire tap_valid,
    input wire tap_ready
);
    localparam DW = LANES * `TWS_LANE_W;
    localparam PW = 2 + AW + LANES + DW + 1;
    // Pins sampled together as one bus through two flops
    reg [PW-1:0] p1_q;
    reg [PW-1:0] p2_q;
    always @(posedge clock) begin
        if (reset) begin
            p1_q <= {PW{1'b0}};
            p2_q <= {PW{1'b0}};
        end else begin
            p1_q <= {load_n, read_not_write, address,
                lane_write_enable_n, data_in, single_clock_mode};
            p2_q <= p1_q;
        end
    end
    wire ld_n_s = p2_q[PW-1];
    wire rnw_s = p2_q[PW-2];
    wire [AW-1:0] addr_s = p2_q[PW-3 -: AW];
    wire [LANES-1:0] be_n_s = p2_q[DW+LANES:DW+1];
    wire [DW-1:0] din_s = p2_q[DW:1];
    wire single_s = p2_q[0];

    wire kp_rise;
    wire kn_rise;
    wire cp_rise;
    wire cn_rise;
    tws_sync u_kp (.clock(clock), .reset(reset), .d(input_strobe_pos),
        .level(), .rise(kp_rise));
    tws_sync u_kn (.clock(clock), .reset(reset), .d(input_strobe_neg),
        .level(), .rise(kn_rise));
    tws_sync u_cp (.clock(clock), .reset(reset), .d(output_strobe_pos),
        .level(), .rise(cp_rise));
    tws_sync u_cn (.clock(clock), .reset(reset), .d(output_strobe_neg),
        .level(), .rise(cn_rise));
    // Single-clock strap taken on the first clock after reset, from p2_q while it still holds its reset zero
    reg strap_q;
    reg strap_done_q;
    always @(posedge clock) begin
        if (reset) begin
            strap_q <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_q <= single_s;
            strap_done_q <= 1'b1;
        end
    end
    wire launch_pos = strap_q ? kp_rise : cp_rise;
    wire launch_neg = strap_q ? kn_rise : cn_rise;

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Posted write register
    reg post_v_q;
    reg [AW-1:0] post_a_q;
    reg [DW-1:0] post_d0_q;
    reg [DW-1:0] post_d1_q;
    reg [LANES-1:0] post_b0_q;
    reg [LANES-1:0] post_b1_q;

    reg [2:0] st_q;
    reg [AW-1:0] wa_q;
    reg [AW-1:0] ra_q;
    reg rd_pend_q;
    reg [AW-1:0] rd_pend_a_q;

    function [DW-1:0] merge;
        input [DW-1:0] old;
        input [DW-1:0] nw;
        input [LANES-1:0] be_n;
        integer i;
        begin
            merge = old;
            for (i = 0; i < LANES; i = i + 1)
                if (!be_n[i])
                    merge[i*`TWS_LANE_W +: `TWS_LANE_W] =
                        nw[i*`TWS_LANE_W +: `TWS_LANE_W];
        end
    endfunction

    function [DW-1:0] rd_word;
        input [AW-1:0] a;
        begin
            rd_word = mem[a];
            if (post_v_q && a == post_a_q)
                rd_word = merge(mem[a], post_d0_q, post_b0_q);
            else if (post_v_q && a == {post_a_q[AW-1:1], ~post_a_q[0]})
                rd_word = merge(mem[a], post_d1_q, post_b1_q);
        end
    endfunction

    wire [AW-1:0] wa_next = {wa_q[AW-1:1], ~wa_q[0]};
    wire [AW-1:0] ra_next = {ra_q[AW-1:1], ~ra_q[0]};

    // Read words pass the buffer before the output stage
    reg rq_v;
    reg [DW-1:0] rq_d;
    wire rq_ready;
    wire ob_valid;
    wire [DW-1:0] ob_data;
    reg ob_take;
    tws_buf2 #(.W(DW)) u_buf (.clock(clock), .reset(reset),
        .in_valid(rq_v), .in_ready(rq_ready), .in_data(rq_d),
        .out_valid(ob_valid), .out_ready(ob_take), .out_data(ob_data));
    assign tap_data = ob_data;
    assign tap_valid = ob_valid;

    reg [1:0] out_ph_q;
    reg stop_q;
    // Word waited through one output pos edge: gives 1.5 cycle latency
    reg arm_q;

    always @(posedge clock) begin
        if (reset) begin
            st_q <= `TWS_ST_IDLE;
            wa_q <= {AW{1'b0}};
            ra_q <= {AW{1'b0}};
            post_v_q <= 1'b0;
            post_a_q <= {AW{1'b0}};
            post_d0_q <= {DW{1'b0}};
            post_d1_q <= {DW{1'b0}};
            post_b0_q <= {LANES{1'b1}};
            post_b1_q <= {LANES{1'b1}};
            rd_pend_q <= 1'b0;
            rd_pend_a_q <= {AW{1'b0}};
        end else begin
            case (st_q)
            `TWS_ST_IDLE, `TWS_ST_RD1: begin
                if (kp_rise && !ld_n_s) begin
                    if (!rnw_s) begin
                        wa_q <= addr_s;
                        st_q <= `TWS_ST_WR1;
                        if (post_v_q) begin
                            mem[post_a_q] <= merge(mem[post_a_q],
                                post_d0_q, post_b0_q);
                            mem[{post_a_q[AW-1:1], ~post_a_q[0]}] <=
                                merge(mem[{post_a_q[AW-1:1],
                                ~post_a_q[0]}], post_d1_q, post_b1_q);
                            post_v_q <= 1'b0;
                        end
                    end else begin
                        rd_pend_q <= 1'b1;
                        rd_pend_a_q <= addr_s;
                        st_q <= `TWS_ST_RD1;
                    end
                end else if (kp_rise) begin
                    st_q <= `TWS_ST_IDLE;
                end
            end
            `TWS_ST_WR1: begin
                if (kp_rise) begin
                    post_d0_q <= din_s;
                    post_b0_q <= be_n_s;
                    post_a_q <= wa_q;
                    st_q <= `TWS_ST_WR2;
                end
            end
            `TWS_ST_WR2: begin
                if (kn_rise) begin
                    post_d1_q <= din_s;
                    post_b1_q <= be_n_s;
                    post_v_q <= 1'b1;
                    st_q <= `TWS_ST_IDLE;
                end
            end
            default: st_q <= `TWS_ST_IDLE;
            endcase
            if (rd_pend_q && rq_ready && !rq_v)
                rd_pend_q <= 1'b0;
            if (rd_pend_q && !rq_v)
                ra_q <= rd_pend_a_q;
        end
    end

    // Burst producer: first word then second word into the buffer
    reg bph_q;
    always @(posedge clock) begin
        if (reset) begin
            bph_q <= 1'b0;
            rq_v <= 1'b0;
            rq_d <= {DW{1'b0}};
        end else if (rq_v && rq_ready) begin
            if (!bph_q) begin
                rq_d <= rd_word(ra_next);
                bph_q <= 1'b1;
            end else begin
                rq_v <= 1'b0;
                bph_q <= 1'b0;
            end
        end else if (!rq_v && rd_pend_q) begin
            rq_v <= 1'b1;
            rq_d <= rd_word(rd_pend_a_q);
        end
    end

    // Output stage: neg launch first word, pos launch second word
    always @* begin
        ob_take = 1'b0;
        if (ob_valid && out_ph_q == 2'h0 && launch_neg && arm_q)
            ob_take = 1'b1;
        if (ob_valid && out_ph_q == 2'h1 && launch_pos)
            ob_take = 1'b1;
    end
    always @(posedge clock) begin
        if (reset) begin
            data_out <= {DW{1'b0}};
            data_oe <= 1'b0;
            out_ph_q <= 2'h0;
            stop_q <= 1'b0;
            arm_q <= 1'b0;
        end else begin
            stop_q <= 1'b0;
            if (ob_take && out_ph_q == 2'h0)
                arm_q <= 1'b0;
            else if (launch_pos && ob_valid && out_ph_q == 2'h0)
                arm_q <= 1'b1;
            if (ob_take) begin
                data_out <= ob_data;
                data_oe <= 1'b1;
                out_ph_q <= (out_ph_q == 2'h0) ? 2'h1 : 2'h0;
                stop_q <= (out_ph_q == 2'h1);
            end else if (launch_pos && data_oe && !ob_valid
                && out_ph_q == 2'h0) begin
                data_oe <= 1'b0;
            end
            // No launch edge, no change: stopped clocks hold state
        end
    end
endmodule // tws_sram

// File: dv/tws_ctrl.sv
// Controller model: makes the link strobes, drives commands and write data.
// Assumes the device samples every pin with the system clock.
`timescale 1ns/1ps
module tws_ctrl (
    input wire clock,
    output logic strobe_pos = 1'b1,
    output logic strobe_neg = 1'b1,
    output logic load_n = 1'b1,
    output logic read_not_write = 1'b1,
    output logic [7:0] address = 8'h00,
    output logic [1:0] lane_write_enable_n = 2'h3,
    output logic [17:0] data_in = 18'h00000,
    input wire [17:0] data_out,
    input wire data_oe
);
    logic [18:0] cap_a;
    logic [18:0] cap_b;
    // Eight clocks: negative half, then positive half; pins move mid-half
    task automatic lc(input logic ld, rnw, input logic [7:0] a,
        input logic [17:0] dp, dn, input logic [1:0] bp, bn);
        @(posedge clock);
        strobe_pos <= 1'b0;
        strobe_neg <= 1'b1;
        @(posedge clock);
        cap_a <= {data_oe, data_out};
        @(posedge clock);
        load_n <= ld;
        read_not_write <= rnw;
        address <= a;
        data_in <= dp;
        lane_write_enable_n <= bp;
        repeat (2) @(posedge clock);
        strobe_pos <= 1'b1;
        strobe_neg <= 1'b0;
        @(posedge clock);
        cap_b <= {data_oe, data_out};
        @(posedge clock);
        data_in <= dn;
        lane_write_enable_n <= bn;
        @(posedge clock);
    endtask
    task automatic park;
        @(posedge clock);
        strobe_neg <= 1'b1;
    endtask
endmodule // tws_ctrl

// File: dv/tws_sram_sva.sv
// Port checker for the burst SRAM device: launch timing, idle, reset.
// Assumes link strobes far slower than clock.
`timescale 1ns/1ps
`include "tws_regs.vh"
module tws_sram_chk #(
    parameter LANES = `TWS_LANES,
    parameter AW = `TWS_ADDR_W
) (
    input wire clock,
    input wire reset,
    input wire input_strobe_pos,
    input wire output_strobe_pos,
    input wire output_strobe_neg,
    input wire load_n,
    input wire read_not_write,
    input wire [LANES*`TWS_LANE_W-1:0] data_out,
    input wire data_oe
);
    logic isp_q, osp_q, osn_q;
    logic [5:0] rd_age_q;
    logic [3:0] os_age_q, op_age_q;
    wire rd_cmd = input_strobe_pos && !isp_q && !load_n && read_not_write;
    wire op_rise = output_strobe_pos && !osp_q;
    wire os_rise = op_rise || (output_strobe_neg && !osn_q);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Ages saturate, so a stopped link reads as quiet
    always @(posedge clock) begin
        isp_q <= input_strobe_pos;
        osp_q <= output_strobe_pos;
        osn_q <= output_strobe_neg;
        if (reset) begin
            rd_age_q <= 6'h3f;
            os_age_q <= 4'hf;
            op_age_q <= 4'hf;
        end else begin
            rd_age_q <= rd_cmd ? 6'h00 : rd_age_q + {5'h00, rd_age_q != 6'h3f};
            os_age_q <= os_rise ? 4'h0 : os_age_q + {3'h0, os_age_q != 4'hf};
            op_age_q <= op_rise ? 4'h0 : op_age_q + {3'h0, op_age_q != 4'hf};
        end
    end
    a_reset_quiet: assert property ($fell(reset) |-> !data_oe)
        else $error("data_oe high after reset");
    a_reset_zero: assert property ($fell(reset) |-> data_out == '0)
        else $error("data_out not cleared by reset");
    a_read_latency: assert property (
        $rose(data_oe) |-> rd_age_q inside {[10:24]})
        else $error("first read word at wrong time");
    a_first_neg: assert property (
        $rose(data_oe) |-> op_age_q inside {[5:10]})
        else $error("first read word not on negative output edge");
    a_burst_width: assert property ($rose(data_oe) |-> data_oe[*8])
        else $error("data_oe dropped inside a burst");
    a_out_launch: assert property (
        $changed(data_out) |-> os_age_q inside {[1:7]})
        else $error("data_out changed away from an output edge");
    a_tristate: assert property (
        $fell(data_oe) |-> op_age_q inside {[1:7]})
        else $error("data_oe released away from a positive edge");
    a_stopped_hold: assert property (
        os_age_q == 4'hf |=> $stable(data_out) && $stable(data_oe))
        else $error("outputs moved with output strobes stopped");
endmodule // tws_sram_chk
bind tws_sram tws_sram_chk #(.LANES(LANES), .AW(AW)) u_tws_sram_chk (
    .clock(clock), .reset(reset), .input_strobe_pos(input_strobe_pos),
    .output_strobe_pos(output_strobe_pos),
    .output_strobe_neg(output_strobe_neg), .load_n(load_n),
    .read_not_write(read_not_write), .data_out(data_out), .data_oe(data_oe));

// File: dv/testbench.sv
// Bench for the burst SRAM device, driven through the controller model.
// Assumes a 20 MHz clock and a 400 ns link period.
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic tap_ready = 1'b1;
    wire sp, sn, ld_n, rnw, oe, tv;
    wire [7:0] adr;
    wire [1:0] ben;
    wire [17:0] din, dout, td;
    logic [17:0] m [0:255];
    int n_mismatch = 0;
    int checks_done = 0;
    always #25 clock = ~clock;
    tws_ctrl u_tws_ctrl (.clock(clock), .strobe_pos(sp), .strobe_neg(sn),
        .load_n(ld_n), .read_not_write(rnw), .address(adr),
        .lane_write_enable_n(ben), .data_in(din), .data_out(dout),
        .data_oe(oe));
    tws_sram u_tws_sram (.clock(clock), .reset(reset),
        .input_strobe_pos(sp), .input_strobe_neg(sn),
        .output_strobe_pos(sp), .output_strobe_neg(sn),
        .single_clock_mode(1'b0), .load_n(ld_n), .read_not_write(rnw),
        .address(adr), .lane_write_enable_n(ben), .data_in(din),
        .data_out(dout), .data_oe(oe), .tap_data(td), .tap_valid(tv),
        .tap_ready(tap_ready));
    task automatic chk(input logic [18:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic logic [17:0] mrg(logic [17:0] o, n, logic [1:0] b);
        mrg = {b[1] ? o[17:9] : n[17:9], b[0] ? o[8:0] : n[8:0]};
    endfunction
    task automatic idle_command;
        u_tws_ctrl.lc(1'b1, 1'b1, 8'h00, 18'h0, 18'h0, 2'h3, 2'h3);
    endtask
    task automatic wr(input logic [7:0] a, input logic [17:0] d0, d1,
        input logic [1:0] b0, b1);
        idle_command();
        u_tws_ctrl.lc(1'b0, 1'b0, a, 18'h0, 18'h0, 2'h3, 2'h3);
        u_tws_ctrl.lc(1'b1, 1'b0, 8'h00, d0, d1, b0, b1);
        m[a] = mrg(m[a], d0, b0);
        m[a ^ 8'h01] = mrg(m[a ^ 8'h01], d1, b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic stop);
        u_tws_ctrl.lc(1'b0, 1'b1, a, 18'h0, 18'h0, 2'h3, 2'h3);
        idle_command();
        idle_command();
        chk(u_tws_ctrl.cap_b, {1'b1, m[a]});
        if (stop) begin
            u_tws_ctrl.park();
            repeat (20) @(posedge clock);
            chk({oe, dout}, {1'b1, m[a ^ 8'h01]});
        end
        idle_command();
        if (!stop) chk(u_tws_ctrl.cap_a, {1'b1, m[a ^ 8'h01]});
        idle_command();
        chk({18'h0, u_tws_ctrl.cap_a[18]}, 19'h0);
    endtask
    task automatic s_burst;
        chk({oe, dout}, 19'h0);
        chk({18'h0, tv}, 19'h0);
        wr(8'h10, 18'h2a5a5, 18'h15a5a, 2'h0, 2'h0);
        rd(8'h10, 1'b0);
        wr(8'h21, 18'h3c3c3, 18'h0f0f0, 2'h0, 2'h0);
        rd(8'h21, 1'b0);
        rd(8'h10, 1'b0);
    endtask
    task automatic s_lanes;
        for (int i = 0; i < 4; i++) begin
            wr(8'h10, 18'h1ffff ^ 18'(i), 18'h12345 + 18'(i), 2'(i), 2'(~i));
            rd(8'h10, 1'b0);
        end
    endtask
    task automatic s_stall;
        tap_ready <= 1'b0;
        rd(8'h21, 1'b0);
        // Burst fully launched: buffer drained whatever tap_ready says
        chk({18'h0, tv}, 19'h0);
        tap_ready <= 1'b1;
        rd(8'h10, 1'b1);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(posedge clock);
        s_burst();
        s_lanes();
        s_stall();
        stop_test();
    end
    initial begin
        repeat (100000) @(posedge clock);
        n_mismatch++;
        stop_test();
    end
endmodule // testbench
